/* File: src/art_pkg.sv */
/*
 package for the auto-reload timer with split and capture modes.
 assumes a byte-wide special-function register port driven by the processor core.
*/
package art_pkg;
	// register addresses on the special-function register port
	localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h91;
	localparam logic [7:0] ADDR_RELOAD_LOW    = 8'hca;
	localparam logic [7:0] ADDR_RELOAD_HIGH   = 8'hcb;
	localparam logic [7:0] ADDR_COUNT_LOW     = 8'hcc;
	localparam logic [7:0] ADDR_COUNT_HIGH    = 8'hcd;
	// control bit positions
	localparam int BIT_HIGH_FLAG   = 7;
	localparam int BIT_LOW_FLAG    = 6;
	localparam int BIT_LOW_IRQ_EN  = 5;
	localparam int BIT_CAPTURE_EN  = 4;
	localparam int BIT_SPLIT       = 3;
	localparam int BIT_RUN         = 2;
	localparam int BIT_RESERVED    = 1;
	localparam int BIT_CLOCK_SEL   = 0;
	// reset values and constants
	localparam logic [7:0] RESET_BYTE   = 8'h00;
	localparam logic [7:0] BYTE_MAX     = 8'hff;
	localparam logic [7:0] CONTROL_WMASK = 8'hfd;
	// prescale ratios
	localparam logic [3:0] SYS_DIV      = 4'hc;
	localparam logic [3:0] EXT_DIV      = 4'h8;
	localparam logic [3:0] ONE4         = 4'h1;
	localparam logic [3:0] ZERO4        = 4'h0;
	// external clock edge detector states
	typedef enum logic [1:0] {
		ART_EXT_LOW  = 2'b00,
		ART_EXT_HIGH = 2'b01
	} art_ext_t;
endpackage

/* File: src/art_timer.sv */
/*
 auto-reload timer: one 16-bit or two 8-bit timers, with capture on the
 falling edge of the low-frequency oscillator output.
 assumes all inputs except arst_n are synchronous to clk, a byte-wide register port with
 single-cycle write and read strobes, and an external processor interrupt enable.
*/
`timescale 1ns/1ps

// Function
// [R1] reload low supplies the low byte value on reload in auto-reload modes.
// [R2] in capture mode reload low receives the captured count low byte.
// [R3] reload high supplies the high byte value on reload in auto-reload modes.
// [R4] in capture mode reload high receives the captured count high byte.
// [R5] count low holds the low byte or whole low timer; software reads, writes.
// [R6] count high holds the high byte or whole high timer; software reads, writes.
// [R7] high overflow flag, bit 7, sets when high byte wraps from ff to 00.
// [R8] high overflow flag raises the timer interrupt when the interrupt is enabled.
// [R9] hardware never clears the overflow flags; software clears by writing zero.
// [R10] low overflow flag, bit 6, sets on every low byte wrap in both modes.
// [R11] low overflow raises an interrupt when bit 5 and interrupt enable set.
// [R12] capture enable, bit 4: oscillator falling edge copies count, raises interrupt.
// [R13] split bit 3 selects one 16-bit timer or two 8-bit timers.
// [R14] run bit 2 enables counting; in split mode only the high byte.
// [R15] reserved bit 1 reads zero; software must write zero.
// [R16] clock select bit 0: system clock over 12, or external over 8.
// [R17] an overflowing byte or word reloads from its reload register on that tick; in capture mode the code wraps it to zero instead.
// [R18] every register clears to zero on reset: stopped, 16-bit, no capture.
module art_timer
(
	input  wire logic       clk,
	input  wire logic       arst_n,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_write,
	input  wire logic       reg_read,
	output logic      [7:0] reg_rdata,
	input  wire logic       ext_clock,
	input  wire logic       lfo_out,
	input  wire logic       timer_irq_enable,
	output logic            timer_irq
);
	import art_pkg::*;

	logic       rst_meta;
	logic       rst_n;
	logic [7:0] timer_control;
	logic [7:0] reload_low;
	logic [7:0] reload_high;
	logic [7:0] count_low;
	logic [7:0] count_high;
	logic [3:0] prescale;
	art_ext_t   ext_state;
	logic       ext_edge;
	logic       lfo_last;
	logic       tick;
	logic       fall;
	logic       split_mode_select;
	logic       run_control;
	logic       capture_enable;
	logic       low_overflow_irq_enable;
	logic       count_clock_select;
	logic       low_wrap;
	logic       high_wrap;
	logic       high_step;
	logic       wr_ctl;
	logic       wr_rll;
	logic       wr_rlh;
	logic       wr_cl;
	logic       wr_ch;
	logic [7:0] next_count_low;
	logic [7:0] next_count_high;

	// address compare used for every register strobe
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_addr);
		return a == ref_addr;
	endfunction

	// reset release through two flip-flops
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// field views and write strobes
	assign split_mode_select       = timer_control[BIT_SPLIT];       // R13
	assign run_control             = timer_control[BIT_RUN];
	assign capture_enable          = timer_control[BIT_CAPTURE_EN];
	assign low_overflow_irq_enable = timer_control[BIT_LOW_IRQ_EN];
	assign count_clock_select      = timer_control[BIT_CLOCK_SEL];
	assign wr_ctl = reg_write && hit(reg_addr, ADDR_TIMER_CONTROL);
	assign wr_rll = reg_write && hit(reg_addr, ADDR_RELOAD_LOW);
	assign wr_rlh = reg_write && hit(reg_addr, ADDR_RELOAD_HIGH);
	assign wr_cl  = reg_write && hit(reg_addr, ADDR_COUNT_LOW);
	assign wr_ch  = reg_write && hit(reg_addr, ADDR_COUNT_HIGH);

	// rising edge detector on the external clock input
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_state <= ART_EXT_LOW;
		end else begin
			case (ext_state)
				ART_EXT_LOW:  ext_state <= ext_clock ? ART_EXT_HIGH : ART_EXT_LOW;
				ART_EXT_HIGH: ext_state <= ext_clock ? ART_EXT_HIGH : ART_EXT_LOW;
				default:      ext_state <= ART_EXT_LOW;
			endcase
		end
	end
	assign ext_edge = (ext_state == ART_EXT_LOW) && ext_clock;

	// prescaler: counts system clocks or external edges
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prescale <= ZERO4;
		end else if (!count_clock_select) begin
			prescale <= (prescale >= SYS_DIV - ONE4) ? ZERO4 : prescale + ONE4; // R16
		end else if (ext_edge) begin
			prescale <= (prescale >= EXT_DIV - ONE4) ? ZERO4 : prescale + ONE4; // R16
		end
	end
	assign tick = count_clock_select ? (ext_edge && prescale >= EXT_DIV - ONE4)
	                                 : (prescale >= SYS_DIV - ONE4);

	// falling edge of the low-frequency oscillator output
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lfo_last <= 1'b0;
		end else begin
			lfo_last <= lfo_out;
		end
	end
	assign fall = lfo_last && !lfo_out;

	// overflow and stepping decisions
	always_comb begin
		low_wrap  = 1'b0;
		high_wrap = 1'b0;
		high_step = 1'b0;
		if (split_mode_select) begin
			low_wrap  = tick && count_low == BYTE_MAX;           // R14 R10
			high_step = tick && run_control;                     // R14
			high_wrap = high_step && count_high == BYTE_MAX;     // R7
		end else begin
			low_wrap  = tick && run_control && count_low == BYTE_MAX;  // R10
			high_step = low_wrap;
			high_wrap = low_wrap && count_high == BYTE_MAX;            // R7
		end
	end

	// next count values, reload on overflow, or zero on overflow in capture mode
	always_comb begin
		next_count_low  = count_low;
		next_count_high = count_high;
		if (low_wrap && !capture_enable) begin
			next_count_low = reload_low;                         // R1 R17
		end else if (low_wrap) begin
			next_count_low = RESET_BYTE;
		end else if (tick && (split_mode_select || run_control)) begin
			next_count_low = count_low + 8'h01;
		end
		if (high_wrap && !capture_enable) begin
			next_count_high = reload_high;                       // R3 R17
		end else if (high_wrap) begin
			next_count_high = RESET_BYTE;
		end else if (high_step) begin
			next_count_high = count_high + 8'h01;
		end
	end

	// counter registers, software write has priority
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count_low  <= RESET_BYTE;                            // R18
			count_high <= RESET_BYTE;
		end else begin
			count_low  <= wr_cl ? reg_wdata : next_count_low;    // R5
			count_high <= wr_ch ? reg_wdata : next_count_high;   // R6
		end
	end

	// reload registers, loaded by software or by capture
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reload_low  <= RESET_BYTE;                           // R18
			reload_high <= RESET_BYTE;
		end else if (capture_enable && fall) begin
			reload_low  <= count_low;                            // R2 R12
			reload_high <= count_high;                           // R4 R12
		end else begin
			if (wr_rll) begin
				reload_low <= reg_wdata;
			end
			if (wr_rlh) begin
				reload_high <= reg_wdata;
			end
		end
	end

	// control register; hardware sets flags, set wins over a software clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			timer_control <= RESET_BYTE;                         // R18
		end else begin
			if (wr_ctl) begin
				timer_control <= reg_wdata & CONTROL_WMASK;      // R15 R9
			end
			if (high_wrap) begin
				timer_control[BIT_HIGH_FLAG] <= 1'b1;            // R7
			end
			if (low_wrap) begin
				timer_control[BIT_LOW_FLAG] <= 1'b1;             // R10
			end
		end
	end

	// interrupt request: flags, low enable and capture events
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			timer_irq <= 1'b0;
		end else begin
			timer_irq <= timer_irq_enable && (timer_control[BIT_HIGH_FLAG]   // R8
			             || (low_overflow_irq_enable && timer_control[BIT_LOW_FLAG]) // R11
			             || (capture_enable && fall));                        // R12
		end
	end

	// read data registered one cycle after the read strobe
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= RESET_BYTE;
		end else if (reg_read) begin
			case (reg_addr)
				ADDR_TIMER_CONTROL: reg_rdata <= timer_control;
				ADDR_RELOAD_LOW:    reg_rdata <= reload_low;
				ADDR_RELOAD_HIGH:   reg_rdata <= reload_high;
				ADDR_COUNT_LOW:     reg_rdata <= count_low;
				ADDR_COUNT_HIGH:    reg_rdata <= count_high;
				default:            reg_rdata <= RESET_BYTE;
			endcase
		end
	end

	// checks
	sequence s_low_top;
		tick && !split_mode_select && run_control && count_low == BYTE_MAX;
	endsequence

	a_low_flag_set: assert property (@(posedge clk) disable iff (!rst_n) // R10
		low_wrap |=> timer_control[BIT_LOW_FLAG])
		else $error("low overflow flag not set");
	a_high_flag_set: assert property (@(posedge clk) disable iff (!rst_n) // R7
		high_wrap |=> timer_control[BIT_HIGH_FLAG])
		else $error("high overflow flag not set");
	a_flags_sticky: assert property (@(posedge clk) disable iff (!rst_n) // R9
		!wr_ctl && timer_control[BIT_HIGH_FLAG] |=> timer_control[BIT_HIGH_FLAG])
		else $error("high flag cleared by hardware");
	a_low_reload: assert property (@(posedge clk) disable iff (!rst_n) // R1
		s_low_top ##0 (!capture_enable && !wr_cl && !wr_rll) |=> count_low == $past(reload_low))
		else $error("low byte not reloaded");
	a_high_reload: assert property (@(posedge clk) disable iff (!rst_n) // R3
		high_wrap && !capture_enable && !wr_ch |=> count_high == $past(reload_high))
		else $error("high byte not reloaded");
	a_capture_copy: assert property (@(posedge clk) disable iff (!rst_n) // R12
		capture_enable && fall |=> reload_low == $past(count_low)
			&& reload_high == $past(count_high))
		else $error("capture did not copy count");
	a_run_stop: assert property (@(posedge clk) disable iff (!rst_n) // R14
		!run_control && !wr_ch |=> count_high == $past(count_high))
		else $error("high byte moved while stopped");
	a_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n) // R15
		!timer_control[BIT_RESERVED])
		else $error("reserved bit set");
	a_irq_high: assert property (@(posedge clk) disable iff (!rst_n) // R8
		timer_irq_enable && timer_control[BIT_HIGH_FLAG] |=> timer_irq)
		else $error("interrupt not raised");
	a_sys_tick: assert property (@(posedge clk) disable iff (!rst_n) // R16
		!count_clock_select && tick ##1 !count_clock_select [*8] |-> !tick)
		else $error("tick spacing below twelve");

	// reset leaves every register and output at zero on the first cycle after release
	a_reset_clear: assert property (@(posedge clk) disable iff (!rst_n) // R18
		$rose(rst_n) |-> timer_control == RESET_BYTE && count_low == RESET_BYTE
			&& count_high == RESET_BYTE && reload_low == RESET_BYTE
			&& reload_high == RESET_BYTE && reg_rdata == RESET_BYTE
			&& prescale == ZERO4 && !timer_irq)
		else $error("register not cleared on reset");

	// software writes land on the next cycle unless a capture takes the reload pair
	a_count_low_write: assert property (@(posedge clk) disable iff (!rst_n) // R5
		wr_cl |=> count_low == $past(reg_wdata))
		else $error("count low write lost");
	a_count_high_write: assert property (@(posedge clk) disable iff (!rst_n) // R6
		wr_ch |=> count_high == $past(reg_wdata))
		else $error("count high write lost");
	a_reload_low_write: assert property (@(posedge clk) disable iff (!rst_n) // R1
		wr_rll && !(capture_enable && fall) |=> reload_low == $past(reg_wdata))
		else $error("reload low write lost");
	a_reload_high_write: assert property (@(posedge clk) disable iff (!rst_n) // R3
		wr_rlh && !(capture_enable && fall) |=> reload_high == $past(reg_wdata))
		else $error("reload high write lost");

	// read data comes from the addressed register and holds between reads
	a_read_control: assert property (@(posedge clk) disable iff (!rst_n) // R7
		reg_read && hit(reg_addr, ADDR_TIMER_CONTROL) |=> reg_rdata == $past(timer_control))
		else $error("control read wrong");
	a_read_count: assert property (@(posedge clk) disable iff (!rst_n) // R6
		reg_read && hit(reg_addr, ADDR_COUNT_HIGH) |=> reg_rdata == $past(count_high))
		else $error("count high read wrong");
	a_rdata_hold: assert property (@(posedge clk) disable iff (!rst_n) // R5
		!reg_read |=> $stable(reg_rdata))
		else $error("read data changed without a read");

	// counting: split low byte runs free, stopped timer holds, capture wraps to zero
	a_split_free: assert property (@(posedge clk) disable iff (!rst_n) // R14
		split_mode_select && tick && !wr_cl && count_low != BYTE_MAX
			|=> count_low == $past(count_low) + 8'h01)
		else $error("split low byte did not step");
	a_stop_hold: assert property (@(posedge clk) disable iff (!rst_n) // R14
		!split_mode_select && !run_control && !wr_cl |=> count_low == $past(count_low))
		else $error("low byte moved while stopped");
	a_capture_wrap: assert property (@(posedge clk) disable iff (!rst_n) // R2
		capture_enable && low_wrap && !wr_cl |=> count_low == RESET_BYTE)
		else $error("low byte reloaded in capture mode");
	a_ext_tick: assert property (@(posedge clk) disable iff (!rst_n) // R16
		count_clock_select && tick |-> ext_edge)
		else $error("tick without an external clock edge");
	a_low_sticky: assert property (@(posedge clk) disable iff (!rst_n) // R9
		!wr_ctl && timer_control[BIT_LOW_FLAG] |=> timer_control[BIT_LOW_FLAG])
		else $error("low flag cleared by hardware");

	// interrupt request follows its gate, the low flag and the capture event
	sequence s_lfo_fall;
		capture_enable && lfo_last && !lfo_out;
	endsequence

	a_irq_gated: assert property (@(posedge clk) disable iff (!rst_n) // R8
		!timer_irq_enable |=> !timer_irq)
		else $error("interrupt raised while disabled");
	a_low_irq: assert property (@(posedge clk) disable iff (!rst_n) // R11
		timer_irq_enable && low_overflow_irq_enable && timer_control[BIT_LOW_FLAG]
			|=> timer_irq)
		else $error("low overflow interrupt not raised");
	a_capture_irq: assert property (@(posedge clk) disable iff (!rst_n) // R12
		s_lfo_fall ##0 timer_irq_enable |=> timer_irq)
		else $error("capture interrupt not raised");
endmodule

/* File: tb/art_testbench.sv */
/*
 self-checking testbench for the auto-reload timer: register access tasks, mode scenarios.
 assumes the design package and timer module are compiled first; clock is 10 MHz.
*/
`timescale 1ns/1ps

module testbench;
	import art_pkg::*;
	logic       clk;
	logic       arst_n;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic       reg_write;
	logic       reg_read;
	logic [7:0] reg_rdata;
	logic       ext_clock;
	logic       lfo_out;
	logic       timer_irq_enable;
	logic       timer_irq;
	logic [7:0] d;
	logic       seen;
	int         fail_count;
	int         comparisons;

	art_timer art_timer_inst (
		.clk              (clk),
		.arst_n           (arst_n),
		.reg_addr         (reg_addr),
		.reg_wdata        (reg_wdata),
		.reg_write        (reg_write),
		.reg_read         (reg_read),
		.reg_rdata        (reg_rdata),
		.ext_clock        (ext_clock),
		.lfo_out          (lfo_out),
		.timer_irq_enable (timer_irq_enable),
		.timer_irq        (timer_irq)
	);

	// 100 ns system clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// prints the counts and the verdict, then stops
	task end_of_test;
		$display("mismatches %0d comparisons %0d", fail_count, comparisons);
		if (fail_count == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// byte and bit comparisons
	task chk8(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task chk1(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// one-cycle write strobe, released on the following edge
	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask

	// read data is registered at the edge that takes the strobe
	task rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		#1 v = reg_rdata;
	endtask

	task rdc(input logic [7:0] a, input logic [7:0] exp);
		rd(a, d);
		chk8(d, exp);
	endtask

	// reads control until the given bit is set, bounded
	task poll(input int b);
		for (int k = 0; k < 60; k++) begin
			rd(ADDR_TIMER_CONTROL, d);
			if (d[b] === 1'b1) break;
		end
		chk1(d[b], 1'b1);
	endtask

	// hang guard, far beyond the few hundred cycles the tests take
	initial begin
		repeat (20000) @(posedge clk);
		$display("watchdog expired");
		fail_count++;
		end_of_test();
	end

	// main sequence
	initial begin
		fail_count = 0;
		comparisons = 0;
		arst_n = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_write = 1'b0;
		reg_read = 1'b0;
		ext_clock = 1'b0;
		lfo_out = 1'b0;
		timer_irq_enable = 1'b0;
		repeat (8) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		// reset values, then an unmapped address
		rdc(ADDR_TIMER_CONTROL, 8'h00);
		rdc(ADDR_RELOAD_LOW, 8'h00);
		rdc(ADDR_RELOAD_HIGH, 8'h00);
		rdc(ADDR_COUNT_LOW, 8'h00);
		rdc(ADDR_COUNT_HIGH, 8'h00);
		rdc(8'h55, 8'h00);
		// read back while stopped; reserved control bit stays zero
		wr(ADDR_RELOAD_LOW, 8'h34);
		wr(ADDR_RELOAD_HIGH, 8'h12);
		wr(ADDR_COUNT_LOW, 8'hfe);
		wr(ADDR_COUNT_HIGH, 8'hff);
		rdc(ADDR_RELOAD_LOW, 8'h34);
		rdc(ADDR_RELOAD_HIGH, 8'h12);
		rdc(ADDR_COUNT_LOW, 8'hfe);
		rdc(ADDR_COUNT_HIGH, 8'hff);
		wr(ADDR_TIMER_CONTROL, 8'hfd);
		rdc(ADDR_TIMER_CONTROL, 8'hfd);
		wr(ADDR_TIMER_CONTROL, 8'h00);
		// 16-bit wrap from ffff reloads the word and sets both flags
		timer_irq_enable <= 1'b1;
		wr(ADDR_TIMER_CONTROL, 8'h04);
		poll(BIT_HIGH_FLAG);
		chk1(d[BIT_LOW_FLAG], 1'b1);
		rdc(ADDR_COUNT_LOW, 8'h34);
		rdc(ADDR_COUNT_HIGH, 8'h12);
		chk1(timer_irq, 1'b1);
		repeat (30) @(posedge clk);
		rd(ADDR_TIMER_CONTROL, d);
		chk1(d[BIT_HIGH_FLAG], 1'b1);
		@(posedge clk);
		timer_irq_enable <= 1'b0;
		repeat (3) @(posedge clk);
		chk1(timer_irq, 1'b0);
		timer_irq_enable <= 1'b1;
		wr(ADDR_TIMER_CONTROL, 8'h00);
		repeat (3) @(posedge clk);
		chk1(timer_irq, 1'b0);
		// split mode: low byte counts with run off, high byte holds
		wr(ADDR_RELOAD_LOW, 8'h50);
		wr(ADDR_COUNT_LOW, 8'hfe);
		wr(ADDR_COUNT_HIGH, 8'h77);
		wr(ADDR_TIMER_CONTROL, 8'h08);
		poll(BIT_LOW_FLAG);
		chk1(d[BIT_HIGH_FLAG], 1'b0);
		rdc(ADDR_COUNT_LOW, 8'h50);
		rdc(ADDR_COUNT_HIGH, 8'h77);
		chk1(timer_irq, 1'b0);
		wr(ADDR_TIMER_CONTROL, 8'h68);
		repeat (3) @(posedge clk);
		chk1(timer_irq, 1'b1);
		// split high byte as its own 8-bit timer
		wr(ADDR_RELOAD_HIGH, 8'h20);
		wr(ADDR_COUNT_HIGH, 8'hff);
		wr(ADDR_TIMER_CONTROL, 8'h0c);
		poll(BIT_HIGH_FLAG);
		rdc(ADDR_COUNT_HIGH, 8'h20);
		wr(ADDR_TIMER_CONTROL, 8'h00);
		// external clock over 8: sixteen rising edges give two ticks
		wr(ADDR_COUNT_LOW, 8'h00);
		wr(ADDR_COUNT_HIGH, 8'h00);
		wr(ADDR_TIMER_CONTROL, 8'h05);
		for (int i = 0; i < 16; i++) begin
			repeat (2) @(posedge clk);
			ext_clock <= 1'b1;
			repeat (2) @(posedge clk);
			ext_clock <= 1'b0;
		end
		repeat (6) @(posedge clk);
		rdc(ADDR_COUNT_LOW, 8'h02);
		// system clock over 12: about ten ticks in 120 cycles
		wr(ADDR_TIMER_CONTROL, 8'h04);
		wr(ADDR_COUNT_LOW, 8'h00);
		repeat (120) @(posedge clk);
		rd(ADDR_COUNT_LOW, d);
		chk1(d >= 8'h09 && d <= 8'h0b, 1'b1);
		wr(ADDR_TIMER_CONTROL, 8'h00);
		// capture on the oscillator falling edge, interrupt as a pulse
		wr(ADDR_COUNT_HIGH, 8'hab);
		wr(ADDR_COUNT_LOW, 8'hcd);
		wr(ADDR_TIMER_CONTROL, 8'h10);
		lfo_out <= 1'b1;
		repeat (3) @(posedge clk);
		lfo_out <= 1'b0;
		seen = 1'b0;
		repeat (4) begin
			@(posedge clk);
			#1 seen = seen | timer_irq;
		end
		chk1(seen, 1'b1);
		chk1(timer_irq, 1'b0);
		rdc(ADDR_RELOAD_LOW, 8'hcd);
		rdc(ADDR_RELOAD_HIGH, 8'hab);
		// capture mode overflow wraps to zero, carries, and keeps the captured low byte
		wr(ADDR_COUNT_LOW, 8'hff);
		wr(ADDR_TIMER_CONTROL, 8'h14);
		poll(BIT_LOW_FLAG);
		rdc(ADDR_COUNT_LOW, 8'h00);
		rdc(ADDR_COUNT_HIGH, 8'hac);
		rdc(ADDR_RELOAD_LOW, 8'hcd);
		wr(ADDR_TIMER_CONTROL, 8'h00);
		end_of_test();
	end
endmodule
